// *** rtl/tesp_timer.sv ***
// Edge-separation measurement and PWM generator timer.
`timescale 1ns/1ps
`include "tesp_defines.svh"

module tesp_timer
    import tesp_pkg::*;
#(
    parameter int CNT_W  = `TESP_CNT_W,
    parameter int TB_DIV = `TESP_INT_TB_DIV
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              reset,
    // Software control
    input  wire tesp_cfg_t         cfg,
    input  wire logic              sw_start,
    input  wire logic              sw_reset,
    input  wire logic [CNT_W-1:0]  initial_count,
    input  wire logic [CNT_W-1:0]  idle_count,
    input  wire logic [CNT_W-1:0]  pulse_count,
    // Pins
    input  wire logic              timer_clock_input,
    input  wire logic              timer_gate_input,
    input  wire logic              timer_aux_input,
    output logic                   timer_pulse_output,
    // Software readback
    output logic [CNT_W-1:0]       current_count,
    output tesp_status_t           status
);

    // ------------------------------------------------------------------
    // Parameter checks
    // ------------------------------------------------------------------
    // These checks act while the design is elaborated, before any clock runs.
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_cnt_w
        $error("Counter width must lie between 2 and 32.");
    end
    // The divider counter is sixteen bits wide, which bounds the division ratio.
    if (TB_DIV < 1 || TB_DIV > 65536) begin : g_bad_tb_div
        $error("Timebase divider must lie between 1 and 65536.");
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // One decrement serves the measurement and both PWM phases. A measurement
    // longer than the initial count wraps through zero, so software must start
    // from a value large enough for the longest separation it expects.
    function automatic logic [CNT_W-1:0] tesp_dec(input logic [CNT_W-1:0] value);
        return value - CNT_W'(1);
    endfunction

    // Sequencer states; the tool is free to choose their codes.
    typedef enum logic [1:0] {
        TESP_ST_IDLE,
        TESP_ST_ARMED,
        TESP_ST_RUN,
        TESP_ST_DONE
    } tesp_state_t;

    // Sequencer state and the measurement or phase count.
    tesp_state_t       state;
    tesp_state_t       next_state;
    logic [CNT_W-1:0]  count;
    logic [CNT_W-1:0]  next_count;

    // Divider and the previous pin levels for edge detection.
    logic [15:0]       div_cnt;
    logic              clk_q;
    logic              gate_q;
    logic              aux_q;

    // Level of the PWM output before polarity is applied.
    logic              pwm_active;
    logic              next_pwm_active;

    // ------------------------------------------------------------------
    // Polarity and edge decoding
    // ------------------------------------------------------------------
    // Polarity is applied before edge detection so one detector serves both senses.
    wire clk_lvl  = timer_clock_input ^ cfg.clk_low_active;
    wire gate_lvl = timer_gate_input  ^ cfg.gate_low_active;
    wire aux_lvl  = timer_aux_input   ^ cfg.aux_low_active;
    // The internal tick is an integer division of ref_clk, so the nominal
    // timebase is only approximated and long measurements carry that ratio error.
    wire int_tick = (div_cnt == 16'(TB_DIV - 1));
    wire ext_tick = clk_lvl & ~clk_q;
    wire tb_tick  = cfg.ext_clk_sel ? ext_tick : int_tick;
    wire gate_rise = gate_lvl & ~gate_q;
    wire aux_rise  = aux_lvl & ~aux_q;
    wire is_pwm    = (cfg.mode == TESP_MODE_PWM);
    wire cnt_end   = (count <= CNT_W'(1));

    // ------------------------------------------------------------------
    // Timebase divider and edge history
    // ------------------------------------------------------------------
    // Free-running divider; its wrap pulse is the internal timebase tick.
    // It runs in every state so the tick phase does not depend on start timing.
    always_ff @(posedge ref_clk) begin
        if (reset || int_tick) begin
            div_cnt <= 16'h0000;
        end else begin
            div_cnt <= div_cnt + 16'h0001;
        end
    end

    // Previous levels for the edge detectors. They reset to the inactive level,
    // which is also the idle level after polarity, so no false edge follows reset.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            clk_q  <= 1'b0;
            gate_q <= 1'b0;
            aux_q  <= 1'b0;
        end else begin
            clk_q  <= clk_lvl;
            gate_q <= gate_lvl;
            aux_q  <= aux_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Sequencing
    // ------------------------------------------------------------------
    // Software reset outranks start so a combined strobe leaves the timer halted.
    // The measurement window is half open: a tick that meets the gate edge is
    // counted, and a tick that meets the auxiliary edge is not.
    always_comb begin
        next_state      = state;
        next_count      = count;
        next_pwm_active = pwm_active;
        if (sw_reset) begin
            next_state      = TESP_ST_IDLE;
            next_count      = initial_count;
            next_pwm_active = 1'b0;
        end else begin
            case (state)
                // Start loads the count for the selected mode; nothing else leaves idle.
                TESP_ST_IDLE: begin
                    if (sw_start) begin
                        next_count = is_pwm ? idle_count : initial_count;
                        next_pwm_active = 1'b0;
                        next_state = is_pwm ? TESP_ST_RUN : TESP_ST_ARMED;
                    end
                end
                TESP_ST_ARMED: begin
                    if (gate_rise) begin
                        next_state = TESP_ST_RUN;
                        // The tick that meets the gate edge opens the first
                        // elapsed period, so it is counted here.
                        if (tb_tick) begin
                            next_count = tesp_dec(count);
                        end
                    end
                end
                TESP_ST_RUN: begin
                    if (!is_pwm) begin
                        if (aux_rise) begin
                            next_state = TESP_ST_DONE;
                        end else if (tb_tick) begin
                            // The count runs down until the auxiliary edge arrives.
                            next_count = tesp_dec(count);
                        end
                    end else if (tb_tick) begin
                        // A zero count phase is skipped after one tick.
                        if (cnt_end) begin
                            next_pwm_active = ~pwm_active;
                            next_count = pwm_active ? idle_count : pulse_count;
                        end else begin
                            next_count = tesp_dec(count);
                        end
                    end
                end
                // The result stands until software restarts or resets the timer.
                TESP_ST_DONE: begin
                    if (sw_start) begin
                        next_count = initial_count;
                        next_state = TESP_ST_ARMED;
                    end
                end
                default: begin
                    next_state = TESP_ST_IDLE;
                end
            endcase
        end
    end

    // State, count and PWM level registers.
    // The count clears on reset; software reset is what loads the initial count.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state      <= TESP_ST_IDLE;
            count      <= '0;
            pwm_active <= 1'b0;
        end else begin
            state      <= next_state;
            count      <= next_count;
            pwm_active <= next_pwm_active;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Outputs are decoded from the next values so that every output register
    // changes at the same edge as the state it reports.
    wire out_active = is_pwm ? next_pwm_active : (next_state == TESP_ST_DONE);
    wire out_level  = out_active ^ cfg.out_low_active;
    wire next_busy  = (next_state == TESP_ST_ARMED) || (next_state == TESP_ST_RUN);
    wire next_done  = (next_state == TESP_ST_DONE);

    // In measurement mode the output flags completion; in PWM mode it carries the PWM level.
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            timer_pulse_output <= 1'b0;
            current_count      <= '0;
            status             <= '0;
        end else begin
            timer_pulse_output <= out_level;
            current_count      <= next_count;
            status.busy        <= next_busy;
            status.done        <= next_done;
        end
    end

endmodule

// *** inc/tesp_defines.svh ***
// Constants of the edge-separation and PWM timer block.
`ifndef TESP_DEFINES_SVH
`define TESP_DEFINES_SVH

// ---------------------------------------------------------------------------
// Widths and timing
// ---------------------------------------------------------------------------
`define TESP_CNT_W         32
`define TESP_REF_CLK_MHZ   250
`define TESP_INT_TB_MHZ    40
// Internal timebase approximated by an integer divider of the reference clock.
`define TESP_INT_TB_DIV    ((`TESP_REF_CLK_MHZ + `TESP_INT_TB_MHZ - 1) / `TESP_INT_TB_MHZ)

`endif

// *** inc/tesp_pkg.sv ***
// Types of the edge-separation and PWM timer block.
package tesp_pkg;

    typedef enum logic {
        TESP_MODE_EDGE_SEP,
        TESP_MODE_PWM
    } tesp_mode_t;

    typedef struct packed {
        tesp_mode_t mode;
        logic       ext_clk_sel;
        logic       clk_low_active;
        logic       gate_low_active;
        logic       aux_low_active;
        logic       out_low_active;
    } tesp_cfg_t;

    typedef struct packed {
        logic busy;
        logic done;
    } tesp_status_t;

endpackage

// *** verif/tesp_pulse_src.sv ***
// Far-side model of the pulse sources at the timer pins.
`timescale 1ns/1ps
module tesp_pulse_src (
    // Bench control
    input  wire logic clk,
    input  wire logic gate_go,
    input  wire logic aux_go,
    input  wire logic ext_run,
    input  wire logic low_act,
    // Pins
    output logic      gate_pin,
    output logic      aux_pin,
    output logic      clk_pin
);
    logic [1:0] g_len = 2'h0;
    logic [1:0] a_len = 2'h0;
    logic [2:0] ph    = 3'h0;
    logic       g_req = 1'b0;
    logic       a_req = 1'b0;
    // Requests are taken at the rising edge so falling-edge bench writes never race them.
    always @(posedge clk) begin
        g_req <= gate_go;
        a_req <= aux_go;
    end
    // Each request makes a two-cycle pulse; the clock stands still outside a frame.
    always @(negedge clk) begin
        g_len <= g_req ? 2'h2 : g_len - 2'(g_len != 2'h0);
        a_len <= a_req ? 2'h2 : a_len - 2'(a_len != 2'h0);
        ph    <= ph + 3'h1;
    end
    assign gate_pin = (g_len != 2'h0) ^ low_act;
    assign aux_pin  = (a_len != 2'h0) ^ low_act;
    assign clk_pin  = (ext_run & ph[2]) ^ low_act;
endmodule

// *** verif/tesp_timer_assertions.sv ***
// Port-level checker of the edge-separation and PWM timer.
`timescale 1ns/1ps
module tesp_timer_assertions
    import tesp_pkg::*;
#(
    parameter int CNT_W = 32
) (
    input wire logic ref_clk, reset, sw_start, sw_reset,
    input wire tesp_cfg_t cfg,
    input wire logic [CNT_W-1:0] initial_count, idle_count, pulse_count, current_count,
    input wire logic timer_clock_input, timer_gate_input, timer_aux_input, timer_pulse_output,
    input wire tesp_status_t status
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    wire edge_m = cfg.mode == TESP_MODE_EDGE_SEP;
    a_start_load: assert property (status == 2'b00 && sw_start && !sw_reset |=>
        current_count == (edge_m ? $past(initial_count) : $past(idle_count))) else $error("bad load");
    a_idle_stays: assert property (status == 2'b00 && !sw_start |=> status == 2'b00)
        else $error("left idle without start");
    a_swreset_halt: assert property (sw_reset |=>
        status == 2'b00 && current_count == $past(initial_count)) else $error("bad soft reset");
    a_count_dec: assert property (edge_m && status.busy && $past(status.busy) &&
        $changed(current_count) && !$past(sw_reset) |-> current_count == $past(current_count) - 1'b1)
        else $error("count step not minus one");
    a_done_stop: assert property (edge_m && status.busy && !sw_reset ##1 !status.busy
        |-> status.done) else $error("busy ended without done");
    a_done_holds: assert property (status.done && !sw_start && !sw_reset |=>
        status.done && $stable(current_count)) else $error("result not held");
    a_done_out: assert property (edge_m && status.done |->
        timer_pulse_output != cfg.out_low_active) else $error("output not active at done");
    a_pwm_phase: assert property (!edge_m && $changed(timer_pulse_output) && !$past(sw_reset)
        && !$past(sw_start) && !$past(reset) |-> current_count == ((timer_pulse_output ^
        cfg.out_low_active) ? $past(pulse_count) : $past(idle_count))) else $error("bad phase load");
    // Main scenarios reached.
    c_done: cover property ($rose(status.done));
    c_pwm: cover property (!edge_m && $rose(timer_pulse_output));
    c_rst: cover property (sw_reset);
    c_restart: cover property (status.done && sw_start && !sw_reset);
endmodule
bind tesp_timer tesp_timer_assertions #(.CNT_W(CNT_W)) u_chk (.ref_clk(ref_clk), .reset(reset),
    .sw_start(sw_start), .sw_reset(sw_reset), .cfg(cfg), .initial_count(initial_count),
    .idle_count(idle_count), .pulse_count(pulse_count), .current_count(current_count),
    .timer_clock_input(timer_clock_input), .timer_gate_input(timer_gate_input),
    .timer_aux_input(timer_aux_input), .timer_pulse_output(timer_pulse_output), .status(status));

// *** verif/tesp_timer_tb_top.sv ***
// Self-checking bench of the edge-separation and PWM timer.
`timescale 1ns/1ps
module tesp_timer_tb_top;
    import tesp_pkg::*;
    logic        ref_clk, reset, sw_start, sw_reset, gate_go, aux_go, ext_run;
    logic        gate_pin, aux_pin, clk_pin, pwm;
    logic [31:0] init_c, idle_c, pulse_c, cur;
    tesp_cfg_t    cfg;
    tesp_status_t st;
    int          n_fail = 0, checks_done = 0, cyc = 0;
    tesp_timer #(.TB_DIV(1)) dut (.ref_clk(ref_clk), .reset(reset), .cfg(cfg),
        .sw_start(sw_start), .sw_reset(sw_reset), .initial_count(init_c), .idle_count(idle_c),
        .pulse_count(pulse_c), .timer_clock_input(clk_pin), .timer_gate_input(gate_pin),
        .timer_aux_input(aux_pin), .timer_pulse_output(pwm), .current_count(cur), .status(st));
    tesp_pulse_src src (.clk(ref_clk), .gate_go(gate_go), .aux_go(aux_go), .ext_run(ext_run),
        .low_act(cfg.gate_low_active), .gate_pin(gate_pin), .aux_pin(aux_pin), .clk_pin(clk_pin));
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test;
        if (n_fail == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic tick(int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic pulse_sw(bit rst);
        sw_reset = rst;
        sw_start = !rst;
        tick(1);
        sw_reset = 0;
        sw_start = 0;
        tick(1);
    endtask
    // Polarity changes go with a soft reset so no result stands across them.
    task automatic setup(tesp_mode_t m, bit ext, bit low);
        pulse_sw(1);
        cfg = '{m, ext, low, low, low, low};
        pulse_sw(1);
    endtask
    task automatic pins(int d);
        gate_go = 1;
        tick(1);
        gate_go = 0;
        tick(d - 1);
        aux_go = 1;
        tick(1);
        aux_go = 0;
    endtask
    task automatic t_idle;
        setup(TESP_MODE_EDGE_SEP, 0, 0);
        pins(4);
        tick(5);
        chk("idle status", 0, 32'(st));
        chk("idle count", init_c, cur);
    endtask
    task automatic t_edge(bit ext, bit low, int d);
        setup(TESP_MODE_EDGE_SEP, ext, low);
        pulse_sw(0);
        chk("start count", init_c, cur);
        ext_run = ext;
        pins(d);
        for (int i = 0; i < 20 && st.done !== 1'b1; i++) tick(1);
        ext_run = 0;
        chk("done", 1, 32'(st.done));
        chk("out", 32'(!low), 32'(pwm));
        // The model's external clock has a period of eight reference cycles.
        if (ext) chk("ext ticks", init_c - 32'(d / 8), cur);
        else chk("separation", init_c - d, cur);
        pulse_sw(0);
        chk("restart status", 32'h2, 32'(st));
        chk("restart count", init_c, cur);
    endtask
    task automatic t_pwm(int idl, int pls, bit low);
        int n_hi, n_lo;
        idle_c = idl;
        pulse_c = pls;
        setup(TESP_MODE_PWM, 0, low);
        pulse_sw(0);
        for (int i = 0; i < 200 && !(pwm ^ low); i++) tick(1);
        for (n_hi = 0; n_hi < 200 && (pwm ^ low); n_hi++) tick(1);
        for (n_lo = 0; n_lo < 200 && !(pwm ^ low); n_lo++) tick(1);
        chk("pulse len", pls, n_hi);
        chk("period", idl + pls, n_hi + n_lo);
        pulse_sw(1);
        tick(8);
        chk("halt status", 0, 32'(st));
        chk("halt count", init_c, cur);
        chk("halt out", 32'(low), 32'(pwm));
    endtask
    // Free-running reference clock of 4 ns.
    initial begin
        ref_clk = 0;
        forever #2 ref_clk = ~ref_clk;
    end
    // Hang guard well above the expected run length.
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            stop_test();
        end
    end
    initial begin
        {reset, sw_start, sw_reset, gate_go, aux_go, ext_run} = 6'h20;
        cfg = '0;
        init_c = 32'h100;
        idle_c = 32'h3;
        pulse_c = 32'h2;
        tick(5);
        reset = 0;
        t_idle();
        t_edge(0, 0, 12);
        t_edge(0, 1, 1);
        t_edge(1, 1, 32);
        t_pwm(3, 2, 0);
        t_pwm(1, 6, 1);
        stop_test();
    end
endmodule
